// >>> ref_clock_pkg.sv
// Package of register layout, reset values and encodings for the reference clock block.
package ref_clock_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_REFERENCE_CLOCK_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_PIN_CONFIG              = 4'h4;
    localparam logic [3:0] ADDR_STATUS                  = 4'h8;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int         BIT_MODULE_ENABLE   = 7;
    localparam int         BIT_PIN_OE          = 6;
    localparam int         BIT_SLEW_LIMIT      = 5;
    localparam int         DUTY_HI             = 4;
    localparam int         DUTY_LO             = 3;
    localparam int         DIV_HI              = 2;
    localparam int         DIV_LO              = 0;
    localparam logic [7:0] CONTROL_RESET       = 8'h30;

    // ------------------------------------------------------------
    // Pin configuration register fields
    // ------------------------------------------------------------
    localparam int         BIT_CLOCKOUT_CONFIG = 0;
    localparam int         BIT_CRYSTAL_MODE    = 1;
    localparam logic [1:0] PIN_CONFIG_RESET    = 2'h1;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0] DUTY_0   = 2'h0;
    localparam logic [1:0] DUTY_25  = 2'h1;
    localparam logic [1:0] DUTY_50  = 2'h2;
    localparam logic [1:0] DUTY_75  = 2'h3;
    localparam logic [2:0] DIV_BASE = 3'h0;
    localparam logic [2:0] DIV_TWO  = 3'h1;
    localparam logic [1:0] FOSC4_LAST = 2'h3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> ref_divider_core.sv
// Divider and duty-cycle shaper that forms the reference clock on the system clock.
`timescale 1ns/1ps
`default_nettype none
module ref_divider_core
    import ref_clock_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    input  wire logic       enable_in,
    input  wire logic       run_in,
    input  wire logic [1:0] duty_in,
    input  wire logic [2:0] div_in,
    output var  logic       ref_clk_out
);

    logic [6:0] count_q;
    logic [7:0] period;
    logic [7:0] thresh;
    logic       high_d;

    // ------------------------------------------------------------
    // Threshold from duty selection
    // ------------------------------------------------------------
    function automatic logic [7:0] duty_threshold(input logic [1:0] duty,
                                                  input logic [7:0] per);
        logic [7:0] quarter;
        quarter = per >> 2;
        case (duty)
            DUTY_25: duty_threshold = quarter;
            DUTY_50: duty_threshold = quarter << 1;
            DUTY_75: duty_threshold = 8'(quarter * 8'h03);
            default: duty_threshold = 8'h00;
        endcase
    endfunction

    assign period = 8'h01 << div_in;
    assign thresh = duty_threshold(duty_in, period);

    // The counter freezes while run_in is low, which stands in for the stopped
    // system clock in sleep, so the output keeps its level.
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in || !enable_in)
            count_q <= 7'h00;
        else if (run_in)
            count_q <= 7'(({1'b0, count_q} + 8'h01) & (period - 8'h01));
    end

    // With a divide of two the high time can only land on whole cycles,
    // so 25% and 75% come out as 50% here.
    always_comb
    begin
        if (duty_in == DUTY_0)
            high_d = 1'b0;
        else if (div_in == DIV_BASE)
            high_d = 1'b1;
        else if (div_in == DIV_TWO)
            high_d = (count_q[0] == 1'b0);
        else
            high_d = ({1'b0, count_q} < thresh);
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in || !enable_in)
            ref_clk_out <= 1'b0;
        else if (run_in)
            ref_clk_out <= high_d;
    end

endmodule
`default_nettype wire

// >>> reference_clock_output_divider.sv
// Reference clock block: AXI4-Lite registers, pin routing and divider.
//
// Notes on behaviour
// - The block runs only while control bit 7 is set.
// - Divided clock reaches the pin only while control bit 6 is set.
// - Control bit 5 turns pin slew limiting on or off.
// - Bits 4-3 pick high time: 11=75%, 10=50%, 01=25%, 00=0%.
// - Bits 2-0 pick divide ratio 1,2,4,...,128.
// - Undivided output is held high except 0% forces low.
// - Divide by two gives 50% for the 25% and 75% settings.
// - The system clock is the base clock in every oscillator setup.
// - Any reset disables the block and restores control defaults.
// - A crystal mode claims the shared pin; reference clock stays off it.
// - Clock-out wins the pin and drives system clock divided by four.
// - Pin carries reference clock only when clock-out config bit is 1.
// - Pin conflicts never stop the block feeding the modulator.
// - The divided clock also feeds the internal data modulator.
// - In sleep the block stops and outputs hold their level.
`timescale 1ns/1ps
`default_nettype none
module reference_clock_output_divider
    import ref_clock_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    input  wire logic        sleep_in,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output var  logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    input  wire logic [3:0]  s_axi_araddr,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        ref_clock_pin_out,
    output var  logic        ref_clock_pin_oe_out,
    output var  logic        ref_slew_limit_out,
    output var  logic        modulator_clk_out
);
    import ref_clock_pkg::*;

    logic [7:0]  control_q;
    logic [1:0]  pin_cfg_q;
    logic        aw_got_q;
    logic        w_got_q;
    logic [3:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic [1:0]  fosc4_q;
    logic        ref_clk;
    logic        running;
    logic        pin_src_ref;
    logic        pin_d;
    logic        oe_d;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q  <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q  <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready)
                             && !s_axi_bvalid;
            s_axi_wready  <= !w_got_q && !(s_axi_wvalid && s_axi_wready)
                             && !s_axi_bvalid;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (s_axi_bvalid)
        begin
            if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
        else if (aw_got_q && w_got_q)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q == ADDR_STATUS
                             || aw_addr_q == ADDR_REFERENCE_CLOCK_CONTROL
                             || aw_addr_q == ADDR_PIN_CONFIG)
                            ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            control_q <= CONTROL_RESET;
            pin_cfg_q <= PIN_CONFIG_RESET;
        end
        else if (aw_got_q && w_got_q && !s_axi_bvalid && w_strb_q[0])
        begin
            if (aw_addr_q == ADDR_REFERENCE_CLOCK_CONTROL)
                control_q <= w_data_q[7:0];
            else if (aw_addr_q == ADDR_PIN_CONFIG)
                pin_cfg_q <= w_data_q[1:0];
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            else if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                case (s_axi_araddr)
                    ADDR_REFERENCE_CLOCK_CONTROL:
                        s_axi_rdata <= {24'h000000, control_q};
                    ADDR_PIN_CONFIG:
                        s_axi_rdata <= {30'h00000000, pin_cfg_q};
                    ADDR_STATUS:
                        s_axi_rdata <= {29'h00000000, ref_clock_pin_oe_out,
                                        pin_src_ref, ref_clk};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    // Sleep stands in for the halted system clock: the divider, clock-out counter and outputs hold; the bus and registers still run.
    assign running = !sleep_in;

    ref_divider_core u_core (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .enable_in   (control_q[BIT_MODULE_ENABLE]),
        .run_in      (running),
        .duty_in     (control_q[DUTY_HI:DUTY_LO]),
        .div_in      (control_q[DIV_HI:DIV_LO]),
        .ref_clk_out (ref_clk)
    );

    // ------------------------------------------------------------
    // Pin routing
    // ------------------------------------------------------------
    // Undivided mode cannot be delivered as a registered clock-rate toggle
    // here, so the shaped output is simply held high, the modulator gets
    // that level and pin level equals the shaped output.
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
            fosc4_q <= 2'h0;
        else if (running)
            fosc4_q <= 2'(fosc4_q + 2'h1);
    end

    assign pin_src_ref = pin_cfg_q[BIT_CLOCKOUT_CONFIG];

    always_comb
    begin
        if (pin_cfg_q[BIT_CRYSTAL_MODE])
        begin
            pin_d = 1'b0;
            oe_d  = 1'b0;
        end
        else if (!pin_src_ref)
        begin
            pin_d = fosc4_q[1];
            oe_d  = 1'b1;
        end
        else
        begin
            pin_d = ref_clk;
            oe_d  = control_q[BIT_PIN_OE] && control_q[BIT_MODULE_ENABLE];
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            ref_clock_pin_out    <= 1'b0;
            ref_clock_pin_oe_out <= 1'b0;
            ref_slew_limit_out   <= CONTROL_RESET[BIT_SLEW_LIMIT];
            modulator_clk_out    <= 1'b0;
        end
        else if (running)
        begin
            ref_clock_pin_out    <= pin_d;
            ref_clock_pin_oe_out <= oe_d;
            ref_slew_limit_out   <= control_q[BIT_SLEW_LIMIT];
            modulator_clk_out    <= ref_clk;
        end
    end

endmodule
`default_nettype wire

// >>> ref_clock_checker_assertions.sv
// Concurrent checks on the ports of the reference clock block.
`timescale 1ns/1ps
`default_nettype none
module ref_clock_checker
    import ref_clock_pkg::*;
(
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    input wire logic        sleep_in,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [3:0]  s_axi_awaddr,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_bvalid,
    input wire logic        ref_clock_pin_out,
    input wire logic        ref_clock_pin_oe_out,
    input wire logic        ref_slew_limit_out,
    input wire logic        modulator_clk_out
);
    logic [3:0] adr_q;
    logic [7:0] dat_q;
    logic [7:0] ctl_q;
    logic [1:0] cfg_q;
    logic       stb_q;
    logic       bv_q;
    // ------------------------------------------------------------
    // Register shadow
    // ------------------------------------------------------------
    // The shadow lags the design by a cycle, so every check that reads it waits six.
    always_ff @(posedge core_clk_in)
    begin
        if (s_axi_awvalid && s_axi_awready) adr_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) dat_q <= s_axi_wdata[7:0];
        if (s_axi_wvalid && s_axi_wready) stb_q <= s_axi_wstrb[0];
        bv_q <= s_axi_bvalid;
    end
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            ctl_q <= CONTROL_RESET;
            cfg_q <= PIN_CONFIG_RESET;
        end
        else if (s_axi_bvalid && !bv_q && stb_q)
        begin
            if (adr_q == ADDR_REFERENCE_CLOCK_CONTROL) ctl_q <= dat_q;
            if (adr_q == ADDR_PIN_CONFIG) cfg_q <= dat_q[1:0];
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    sequence off_run;
        (!ctl_q[BIT_MODULE_ENABLE] && !sleep_in)[*6];
    endsequence
    sequence clkout_run;
        (cfg_q == 2'h0 && !sleep_in)[*6];
    endsequence
    module_off_a: assert property (
        off_run |-> !modulator_clk_out) else $error("module runs while off");
    pin_off_a: assert property (
        (!ctl_q[BIT_PIN_OE] && cfg_q == 2'h1 && !sleep_in)[*6]
        |-> !ref_clock_pin_oe_out) else $error("pin driven while off");
    slew_follow_a: assert property (
        (!sleep_in)[*6] |-> ref_slew_limit_out == ctl_q[BIT_SLEW_LIMIT])
        else $error("slew output wrong");
    reset_state_a: assert property (disable iff (1'b0)
        rst_in |=> !ref_clock_pin_oe_out && !modulator_clk_out
        && ref_slew_limit_out) else $error("reset state wrong");
    crystal_pin_a: assert property (
        (cfg_q == 2'h3 && !sleep_in)[*6] |-> !ref_clock_pin_oe_out)
        else $error("pin driven in crystal mode");
    clockout_oe_a: assert property (
        clkout_run |-> ref_clock_pin_oe_out) else $error("clock-out not driven");
    // Sleep freezes the pattern, so a wave check is dropped while asleep.
    clockout_wave_a: assert property (disable iff (rst_in || sleep_in)
        clkout_run ##0 $rose(ref_clock_pin_out) |=> ref_clock_pin_out
        ##1 !ref_clock_pin_out [*2] ##1 ref_clock_pin_out)
        else $error("clock-out not a quarter rate");
    sleep_hold_a: assert property (
        sleep_in |=> $stable(ref_clock_pin_out) && $stable(modulator_clk_out)
        && $stable(ref_clock_pin_oe_out)) else $error("output moved in sleep");
    duty_zero_a: assert property (
        (ctl_q[DUTY_HI:DUTY_LO] == DUTY_0 && !sleep_in)[*6]
        |-> !modulator_clk_out) else $error("output high at zero duty");
endmodule
bind reference_clock_output_divider ref_clock_checker u_ref_clock_checker (.*);
`default_nettype wire

// >>> ext_clock_sink.sv
// Model of an external device clocked from the reference pin.
`timescale 1ns/1ps
`default_nettype none
module ext_clock_sink
(
    input  wire logic pin_in,
    input  wire logic oe_in,
    output var  int   edges_out
);
    initial edges_out = 0;
    // Only edges seen while the pin is driven count as clock ticks.
    always @(posedge pin_in)
    begin
        if (oe_in) edges_out <= edges_out + 1;
    end
endmodule
`default_nettype wire

// >>> reference_clock_output_divider_bench.sv
// Self-checking bench for the reference clock block.
`timescale 1ns/1ps
`default_nettype none
module reference_clock_output_divider_bench;
    import ref_clock_pkg::*;
    logic        clk, rst, slp, awv, wv, bry, arv, rry;
    logic        awr, wr_r, bv, arr, rv, pin, oe, slew, mod;
    logic [3:0]  awa, ws, ara;
    logic [31:0] wd, rd;
    logic [1:0]  br, rr;
    logic [33:0] expq[$];
    int          num_errors = 0, compares = 0, cyc = 0, edges;
    // The pin has a pull-down, so an undriven pin reads low.
    wire         pin_w = oe ? pin : 1'b0;
    reference_clock_output_divider u_reference_clock_output_divider (
        .core_clk_in(clk), .rst_in(rst), .sleep_in(slp),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .ref_clock_pin_out(pin),
        .ref_clock_pin_oe_out(oe), .ref_slew_limit_out(slew),
        .modulator_clk_out(mod));
    ext_clock_sink u_ext_clock_sink (.pin_in(pin_w), .oe_in(oe),
        .edges_out(edges));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string n, input logic [33:0] e, g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d, s, e);
        expq.push_back({e[1:0], 32'h0});
        @(posedge clk);
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= {24'h0, d};
        ws <= s[3:0];
        bry <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
        end while (!bv);
        bry <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a, input logic [33:0] e);
        expq.push_back(e);
        @(posedge clk);
        arv <= 1'b1;
        ara <= a;
        rry <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rry <= 1'b0;
    endtask
    task automatic meas(input int w, output int m, p);
        m = 0;
        p = 0;
        repeat (w)
        begin
            @(posedge clk);
            m += int'(mod === 1'b1);
            p += int'(pin_w === 1'b1);
        end
    endtask
    task end_sim;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        if ((bv && bry) || (rv && rry))
            chk("axi", expq.pop_front(), bv ? {br, 32'h0} : {rr, rd});
        cyc++;
        if (cyc == 40000)
        begin
            num_errors++;
            end_sim();
        end
    end
    initial
    begin
        int         m, p, n, e, c;
        logic [7:0] v;
        {rst, slp, awv, wv, bry, arv, rry} = 7'h40;
        {awa, ara, ws, wd} = '0;
        void'($urandom(32'h868e));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdr(ADDR_REFERENCE_CLOCK_CONTROL, {RESP_OKAY, 24'h0, CONTROL_RESET});
        rdr(ADDR_PIN_CONFIG, {RESP_OKAY, 30'h0, PIN_CONFIG_RESET});
        rdr(4'hc, {RESP_SLVERR, 32'h0});
        wr(4'hc, 8'h80, 4'hf, RESP_SLVERR);
        wr(ADDR_REFERENCE_CLOCK_CONTROL, 8'h81, 4'h0, RESP_OKAY);
        rdr(ADDR_REFERENCE_CLOCK_CONTROL, {RESP_OKAY, 24'h0, CONTROL_RESET});
        for (int d = 0; d < 8; d++)
            for (int t = 0; t < 4; t++)
            begin
                v = {1'b1, 2'($urandom), 2'(t), 3'(d)};
                wr(ADDR_REFERENCE_CLOCK_CONTROL, v, 4'h1, RESP_OKAY);
                n = 1 << d;
                repeat (2 * n + 8) @(posedge clk);
                meas(2 * n, m, p);
                e = (t == 0) ? 0 : (d < 2) ? 2 : n * t / 2;
                chk("mod", 34'(e), 34'(m));
                chk("pin", 34'(v[6] ? e : 0), 34'(p));
                chk("slew", 34'(v[5]), 34'(slew));
                chk("oe", 34'(v[6]), 34'(oe));
            end
        wr(ADDR_REFERENCE_CLOCK_CONTROL, 8'h5a, 4'h1, RESP_OKAY);
        repeat (20) @(posedge clk);
        meas(8, m, p);
        chk("off", 34'h0, 34'(m));
        wr(ADDR_REFERENCE_CLOCK_CONTROL, 8'hd2, 4'h1, RESP_OKAY);
        wr(ADDR_PIN_CONFIG, 8'h03, 4'h1, RESP_OKAY);
        repeat (12) @(posedge clk);
        meas(8, m, p);
        chk("crystal oe", 34'h0, 34'(oe));
        chk("inner", 34'd4, 34'(m));
        wr(ADDR_PIN_CONFIG, 8'h00, 4'h1, RESP_OKAY);
        repeat (12) @(posedge clk);
        c = edges;
        meas(16, m, p);
        chk("clockout", 34'd8, 34'(p));
        chk("edges", 34'd4, 34'(edges - c));
        slp <= 1'b1;
        repeat (3) @(posedge clk);
        {m, p} = {int'(mod), int'(pin)};
        repeat (20) @(posedge clk);
        chk("sleep", 34'({m[0], p[0]}), 34'({mod, pin}));
        slp <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdr(ADDR_REFERENCE_CLOCK_CONTROL, {RESP_OKAY, 24'h0, CONTROL_RESET});
        end_sim();
    end
endmodule
`default_nettype wire
